// File: inc/lcs_pkg.sv
// constants and types for the logic cell storage and control block
package lcs_pkg;
    localparam int CTRL_SEL_W = 2;
    localparam int NUM_CTRL = 4;
    localparam int ADDR_W = 4;
    localparam int DEPTH = 16;
    localparam int DEPTH_WIDE = 32;
    // control signal slots
    localparam int SLOT_CE = 0;
    localparam int SLOT_PRESET_CLEAR = 1;
    localparam int SLOT_DIN = 2;
    localparam int SLOT_THIRD_ONE = 3;
    // reset values of configured state
    localparam logic INIT_CLEAR = 1'h0;
    localparam logic INIT_PRESET = 1'h1;
    typedef enum logic [1:0] {
        LCS_SRC_F,
        LCS_SRC_G,
        LCS_SRC_H,
        LCS_SRC_DIN
    } lcs_src_t;
    typedef enum logic [1:0] {
        LCS_MEM_OFF,
        LCS_MEM_LEVEL,
        LCS_MEM_EDGE,
        LCS_MEM_DUAL
    } lcs_mem_mode_t;
    typedef enum logic [1:0] {
        LCS_SHAPE_16X2,
        LCS_SHAPE_32X1,
        LCS_SHAPE_16X1
    } lcs_shape_t;
endpackage

// File: logic/lcs_storage.sv
// one storage element: flip-flop or latch with configured preset/clear
module lcs_storage (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic global_preset_clear_i,
    input wire logic local_async_preset_clear_i,
    input wire logic local_preset_clear_enable_i,
    input wire logic init_preset_i,
    input wire logic latch_mode_i,
    input wire logic storage_clock_enable_i,
    input wire logic d_i,
    output logic q_o
);
    import lcs_pkg::*;
    logic held;
    wire force_init = reset_i | global_preset_clear_i |
        (local_preset_clear_enable_i & local_async_preset_clear_i); // RULE4 RULE5 RULE2 RULE3
    wire next_held = force_init ? init_preset_i :
        (storage_clock_enable_i ? d_i : held); // RULE1 RULE17 RULE13
    always_ff @(posedge clk_i) begin
        held <= next_held;
    end
    // latch mode passes data through while enabled
    always_comb begin
        if (force_init) begin
            q_o = init_preset_i; // RULE17
        end else if (latch_mode_i && storage_clock_enable_i) begin
            q_o = d_i; // RULE13
        end else begin
            q_o = held;
        end
    end
    property p_hold_init;
        @(posedge clk_i)
            force_init
            |=> held == $past(init_preset_i);
    endproperty
    a_hold_init: assert property (p_hold_init) // RULE17
        else $error("element left configured state");

    property p_enable_hold;
        @(posedge clk_i)
            !force_init && !storage_clock_enable_i
            |=> held == $past(held);
    endproperty
    a_enable_hold: assert property (p_enable_hold) // RULE13
        else $error("element changed without clock enable");
endmodule // lcs_storage

// File: logic/lcs_cell.sv
// storage and control portion of a configurable logic cell
// What this block does
// RULE1: one config bit picks preset or clear
// RULE2: per-element init choice and local disable
// RULE3: local set/reset active high, not invertible
// RULE4: global net forces configured state
// RULE5: preset/clear same for local and global
// RULE6: global net driven from pin or node
// RULE7: data input from F, G, H or direct
// RULE8: outputs bypass mux to any control input
// RULE9: any control input drives any slot
// RULE10: logic mode slot meanings
// RULE11: memory mode slot meanings
// RULE12: storage usable alongside independent logic
// RULE13: flip-flop with enable, clear, or latch
// RULE14: tables as level, edge or dual-port memory
// RULE15: shapes 16x2, 32x1 or 16x1
// RULE16: 32x1 shares address, extra bit selects table
// RULE17: set/reset overrides capture and enable
module lcs_cell (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic global_preset_clear_i,
    input wire logic [lcs_pkg::NUM_CTRL-1:0] cell_control_inputs_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] sel_ce_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] sel_preset_clear_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] sel_din_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] sel_third_one_i,
    input wire logic [1:0] init_preset_i,
    input wire logic [1:0] local_preset_clear_enable_i,
    input wire logic [1:0] latch_mode_i,
    input wire lcs_pkg::lcs_src_t src_x_i,
    input wire lcs_pkg::lcs_src_t src_y_i,
    input wire logic [1:0] bypass_en_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] bypass_sel_x_i,
    input wire logic [lcs_pkg::CTRL_SEL_W-1:0] bypass_sel_y_i,
    input wire lcs_pkg::lcs_mem_mode_t mem_mode_i,
    input wire lcs_pkg::lcs_shape_t mem_shape_i,
    input wire logic [lcs_pkg::ADDR_W-1:0] f_addr_i,
    input wire logic [lcs_pkg::ADDR_W-1:0] g_addr_i,
    input wire logic [lcs_pkg::ADDR_W-1:0] dual_read_addr_i,
    input wire logic [lcs_pkg::DEPTH-1:0] f_table_init_i,
    input wire logic [lcs_pkg::DEPTH-1:0] g_table_init_i,
    input wire logic h_table_out_i,
    output logic first_registered_out_o,
    output logic second_registered_out_o,
    output logic f_out_o,
    output logic g_out_o,
    output logic dual_out_o,
    output logic storage_clock_enable_o,
    output logic local_async_preset_clear_o,
    output logic third_lut_input_zero_o,
    output logic third_lut_input_one_o,
    output logic third_lut_input_two_o
);
    import lcs_pkg::*;
    logic [DEPTH-1:0] f_table;
    logic [DEPTH-1:0] g_table;
    logic [1:0] q_elem;

    // control slot routing
    wire storage_clock_enable = cell_control_inputs_i[sel_ce_i]; // RULE9 RULE10 RULE11
    wire slot_preset_clear = cell_control_inputs_i[sel_preset_clear_i]; // RULE9
    wire slot_din = cell_control_inputs_i[sel_din_i]; // RULE9
    wire third_lut_input_one = cell_control_inputs_i[sel_third_one_i]; // RULE9
    wire mem_on = mem_mode_i != LCS_MEM_OFF;

    // memory mode reuses slots as write enable and data
    wire write_enable = mem_on & slot_preset_clear; // RULE11
    wire table_data_in_low = slot_din; // RULE11
    wire table_data_in_high_or_addr = third_lut_input_one; // RULE11
    // local set/reset only in logic mode
    wire local_async_preset_clear = ~mem_on & slot_preset_clear; // RULE10 RULE3

    wire wide = mem_shape_i == LCS_SHAPE_32X1;
    wire single = mem_shape_i == LCS_SHAPE_16X1;
    wire [ADDR_W-1:0] g_waddr = wide ? f_addr_i : g_addr_i; // RULE16
    wire f_wr = write_enable & (~wide | ~table_data_in_high_or_addr); // RULE15 RULE16
    wire g_wr = write_enable & ~single & (~wide | table_data_in_high_or_addr); // RULE15 RULE16
    wire g_wdata = wide ? table_data_in_low : table_data_in_high_or_addr; // RULE11
    // level mode writes while enabled on each clock; edge modes gated by enable
    wire wr_strobe = (mem_mode_i == LCS_MEM_LEVEL) | storage_clock_enable; // RULE14
    wire f_read = f_table[f_addr_i];
    wire g_read = g_table[g_waddr];
    wire f_out = (wide && table_data_in_high_or_addr) ? g_read : f_read; // RULE16
    wire dual_read = f_table[dual_read_addr_i]; // RULE14

    wire [1:0] d_sel;
    wire [NUM_CTRL-1:0] fn_x = {slot_din, h_table_out_i, g_read, f_out};
    wire [NUM_CTRL-1:0] fn_y = {slot_din, h_table_out_i, g_read, f_out};
    assign d_sel[0] = fn_x[src_x_i]; // RULE7
    assign d_sel[1] = fn_y[src_y_i]; // RULE7
    wire [CTRL_SEL_W-1:0] byp_sel [2];
    assign byp_sel[0] = bypass_sel_x_i;
    assign byp_sel[1] = bypass_sel_y_i;
    wire [1:0] next_out;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            f_table <= f_table_init_i;
            g_table <= g_table_init_i;
        end else if (wr_strobe) begin
            if (f_wr) begin
                f_table[f_addr_i] <= table_data_in_low; // RULE14
            end
            if (g_wr) begin
                g_table[g_waddr] <= g_wdata; // RULE14 RULE15
            end
        end
    end

    // storage independent of tables so logic runs unrelated
    for (genvar i = 0; i < 2; i++) begin : g_elem
        lcs_storage u_storage (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .global_preset_clear_i(global_preset_clear_i),
            .local_async_preset_clear_i(local_async_preset_clear),
            .local_preset_clear_enable_i(local_preset_clear_enable_i[i]),
            .init_preset_i(init_preset_i[i]),
            .latch_mode_i(latch_mode_i[i]),
            .storage_clock_enable_i(storage_clock_enable),
            .d_i(d_sel[i]),
            .q_o(q_elem[i])
        ); // RULE12 RULE2
        assign next_out[i] = bypass_en_i[i] ? cell_control_inputs_i[byp_sel[i]] :
            q_elem[i]; // RULE8
    end

    always_ff @(posedge clk_i) begin
        first_registered_out_o <= next_out[0]; // RULE8
        second_registered_out_o <= next_out[1]; // RULE8
        f_out_o <= f_out;
        g_out_o <= g_read;
        dual_out_o <= dual_read;
        storage_clock_enable_o <= storage_clock_enable;
        local_async_preset_clear_o <= local_async_preset_clear;
        third_lut_input_zero_o <= slot_preset_clear; // RULE10
        third_lut_input_one_o <= third_lut_input_one; // RULE10
        third_lut_input_two_o <= slot_din; // RULE10
    end

    // RULE6: the global net arrives here already routed from a pin or node
    property p_global_forces;
        @(posedge clk_i) disable iff (reset_i)
            global_preset_clear_i && !bypass_en_i[0]
            |=> first_registered_out_o == $past(init_preset_i[0]);
    endproperty
    a_global_forces: assert property (p_global_forces) // RULE4
        else $error("global net did not force first output");

    property p_local_first;
        @(posedge clk_i) disable iff (reset_i)
            local_async_preset_clear && local_preset_clear_enable_i[0] && !bypass_en_i[0]
            |=> first_registered_out_o == $past(init_preset_i[0]);
    endproperty
    a_local_first: assert property (p_local_first) // RULE5
        else $error("local set/reset ignored on first element");

    property p_local_second;
        @(posedge clk_i) disable iff (reset_i)
            local_async_preset_clear && local_preset_clear_enable_i[1] && !bypass_en_i[1]
            |=> second_registered_out_o == $past(init_preset_i[1]);
    endproperty
    a_local_second: assert property (p_local_second) // RULE5
        else $error("local set/reset ignored on second element");

    property p_no_mem_write;
        @(posedge clk_i) disable iff (reset_i)
            !mem_on
            |=> f_table == $past(f_table);
    endproperty
    a_no_mem_write: assert property (p_no_mem_write) // RULE14
        else $error("table changed outside memory mode");

    property p_bypass_first;
        @(posedge clk_i) disable iff (reset_i)
            bypass_en_i[0]
            |=> first_registered_out_o == $past(cell_control_inputs_i[bypass_sel_x_i]);
    endproperty
    a_bypass_first: assert property (p_bypass_first) // RULE8
        else $error("first bypass path wrong");

    property p_bypass_second;
        @(posedge clk_i) disable iff (reset_i)
            bypass_en_i[1]
            |=> second_registered_out_o == $past(cell_control_inputs_i[bypass_sel_y_i]);
    endproperty
    a_bypass_second: assert property (p_bypass_second) // RULE8
        else $error("second bypass path wrong");

    property p_ce_route;
        @(posedge clk_i) disable iff (reset_i)
            1'h1
            |=> storage_clock_enable_o == $past(cell_control_inputs_i[sel_ce_i]);
    endproperty
    a_ce_route: assert property (p_ce_route) // RULE10
        else $error("enable slot not routed");

    property p_zero_route;
        @(posedge clk_i) disable iff (reset_i)
            1'h1
            |=> third_lut_input_zero_o == $past(cell_control_inputs_i[sel_preset_clear_i]);
    endproperty
    a_zero_route: assert property (p_zero_route) // RULE10
        else $error("set/reset slot not routed");

    property p_one_route;
        @(posedge clk_i) disable iff (reset_i)
            1'h1
            |=> third_lut_input_one_o == $past(cell_control_inputs_i[sel_third_one_i]);
    endproperty
    a_one_route: assert property (p_one_route) // RULE9
        else $error("third input one slot not routed");

    property p_two_route;
        @(posedge clk_i) disable iff (reset_i)
            1'h1
            |=> third_lut_input_two_o == $past(cell_control_inputs_i[sel_din_i]);
    endproperty
    a_two_route: assert property (p_two_route) // RULE10
        else $error("direct input slot not routed");

    property p_mem_blocks_local;
        @(posedge clk_i) disable iff (reset_i)
            mem_on
            |=> !local_async_preset_clear_o;
    endproperty
    a_mem_blocks_local: assert property (p_mem_blocks_local) // RULE11
        else $error("local set/reset active in memory mode");

    property p_single_keeps_g;
        @(posedge clk_i) disable iff (reset_i)
            mem_on && single
            |=> g_table == $past(g_table);
    endproperty
    a_single_keeps_g: assert property (p_single_keeps_g) // RULE15
        else $error("second table written in single table shape");

    property p_wide_keeps_f;
        @(posedge clk_i) disable iff (reset_i)
            mem_on && wide && table_data_in_high_or_addr
            |=> f_table == $past(f_table);
    endproperty
    a_wide_keeps_f: assert property (p_wide_keeps_f) // RULE16
        else $error("first table written with upper address set");
endmodule // lcs_cell

// File: sim/lcs_route_model.sv
// routing-side model: global net source and third generator
module lcs_route_model (
    input wire logic pin_i,
    input wire logic invert_i,
    input wire logic in_zero_i,
    input wire logic in_one_i,
    input wire logic in_two_i,
    output logic global_preset_clear_o,
    output logic h_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign global_preset_clear_o = pin_i ^ invert_i;
    assign h_out_o = in_zero_i ^ in_one_i ^ in_two_i;
endmodule // lcs_route_model

// File: sim/lcs_cell_tb_top.sv
// testbench for the logic cell storage and control block
module lcs_cell_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lcs_pkg::*;
    localparam logic [3:0] EXP_SRC = 4'h9;
    logic clk_i = 1'h0, reset_i = 1'h1, pin_i = 1'h0, inv_i = 1'h0;
    logic global_preset_clear_i, h_table_out_i, first_registered_out_o, f_out_o;
    logic second_registered_out_o, storage_clock_enable_o, local_async_preset_clear_o;
    logic g_out_o, dual_out_o;
    logic third_lut_input_zero_o, third_lut_input_one_o, third_lut_input_two_o;
    logic [3:0] cell_control_inputs_i = 4'hB, f_addr_i = 4'h0, g_addr_i = 4'h0;
    logic [3:0] dual_read_addr_i = 4'h0;
    logic [1:0] sel_ce_i = 2'h0, sel_preset_clear_i = 2'h2, sel_din_i = 2'h1;
    logic [1:0] sel_third_one_i = 2'h3, init_preset_i = 2'h1, latch_mode_i = 2'h0;
    logic [1:0] local_preset_clear_enable_i = 2'h1;
    logic [1:0] bypass_en_i = 2'h0, bypass_sel_x_i = 2'h2, bypass_sel_y_i = 2'h1;
    logic [15:0] f_table_init_i = 16'h0001, g_table_init_i = 16'h0000;
    lcs_src_t src_x_i = LCS_SRC_DIN, src_y_i = LCS_SRC_DIN;
    lcs_mem_mode_t mem_mode_i = LCS_MEM_OFF;
    lcs_shape_t mem_shape_i = LCS_SHAPE_16X2;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    lcs_cell dut (.clk_i, .reset_i, .global_preset_clear_i, .cell_control_inputs_i, .sel_ce_i,
        .sel_preset_clear_i, .sel_din_i, .sel_third_one_i, .init_preset_i,
        .local_preset_clear_enable_i, .latch_mode_i,
        .src_x_i, .src_y_i, .bypass_en_i, .bypass_sel_x_i, .bypass_sel_y_i, .mem_mode_i,
        .mem_shape_i, .f_addr_i, .g_addr_i, .dual_read_addr_i, .f_table_init_i,
        .g_table_init_i, .h_table_out_i, .first_registered_out_o, .second_registered_out_o,
        .f_out_o, .g_out_o, .dual_out_o, .storage_clock_enable_o,
        .local_async_preset_clear_o, .third_lut_input_zero_o, .third_lut_input_one_o,
        .third_lut_input_two_o);
    lcs_route_model peer (.pin_i, .invert_i(inv_i), .in_zero_i(third_lut_input_zero_o),
        .in_one_i(third_lut_input_one_o), .in_two_i(third_lut_input_two_o),
        .global_preset_clear_o(global_preset_clear_i), .h_out_o(h_table_out_i));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic pair(input logic x, input logic y);
        chk(first_registered_out_o, x);
        chk(second_registered_out_o, y);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'h0;
        #1;
        pair(1'h1, 1'h0);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            src_x_i <= lcs_src_t'(s);
            src_y_i <= lcs_src_t'(s);
            settle();
            pair(EXP_SRC[s], EXP_SRC[s]);
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            sel_third_one_i <= 2'(s);
            settle();
            chk(third_lut_input_one_o, cell_control_inputs_i[s]);
        end
        chk(storage_clock_enable_o, 1'h1);
        $display("test routing done");
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h1;
        settle();
        pair(1'h0, 1'h0);
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h5;
        settle();
        pair(1'h1, 1'h0);
        chk(local_async_preset_clear_o, 1'h1);
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h3;
        pin_i <= 1'h1;
        settle();
        pair(1'h1, 1'h0);
        @(posedge clk_i);
        inv_i <= 1'h1;
        settle();
        pair(1'h1, 1'h1);
        $display("test set reset done");
        @(posedge clk_i);
        bypass_en_i <= 2'h3;
        settle();
        pair(1'h0, 1'h1);
        @(posedge clk_i);
        mem_mode_i <= LCS_MEM_EDGE;
        f_addr_i <= 4'h5;
        dual_read_addr_i <= 4'h5;
        cell_control_inputs_i <= 4'hF;
        settle();
        chk(local_async_preset_clear_o, 1'h0);
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h3;
        settle();
        chk(f_out_o, 1'h1);
        chk(g_out_o, 1'h1);
        chk(dual_out_o, 1'h1);
        @(posedge clk_i);
        mem_mode_i <= LCS_MEM_LEVEL;
        f_addr_i <= 4'h7;
        cell_control_inputs_i <= 4'h6;
        settle();
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h0;
        settle();
        chk(f_out_o, 1'h1);
        $display("test bypass and memory done");
        @(posedge clk_i);
        mem_mode_i <= LCS_MEM_EDGE;
        mem_shape_i <= LCS_SHAPE_32X1;
        f_addr_i <= 4'h3;
        cell_control_inputs_i <= 4'hF;
        settle();
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h9;
        settle();
        chk(f_out_o, 1'h1);
        chk(g_out_o, 1'h1);
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h1;
        settle();
        chk(f_out_o, 1'h0);
        @(posedge clk_i);
        mem_shape_i <= LCS_SHAPE_16X1;
        cell_control_inputs_i <= 4'hF;
        settle();
        @(posedge clk_i);
        cell_control_inputs_i <= 4'h1;
        settle();
        chk(f_out_o, 1'h1);
        chk(g_out_o, 1'h0);
        $display("test memory shapes done");
        @(posedge clk_i);
        mem_mode_i <= LCS_MEM_OFF;
        bypass_en_i <= 2'h0;
        init_preset_i <= 2'h2;
        cell_control_inputs_i <= 4'h2;
        inv_i <= 1'h0;
        settle();
        pair(1'h0, 1'h1);
        @(posedge clk_i);
        inv_i <= 1'h1;
        settle();
        pair(1'h0, 1'h1);
        @(posedge clk_i);
        latch_mode_i <= 2'h3;
        cell_control_inputs_i <= 4'h3;
        settle();
        pair(1'h1, 1'h1);
        @(posedge clk_i);
        local_preset_clear_enable_i <= 2'h2;
        cell_control_inputs_i <= 4'h5;
        settle();
        pair(1'h0, 1'h1);
        $display("test configured state done");
        finish_test();
    end
endmodule // lcs_cell_tb_top
